// ---- verilog/dcrs_sequencer.sv ----
// Duty-cycled sniff sequencer with RC trim and auto-transition engine
// How it works
// - Idle and receive windows last multiplier (1..255) times selected step.
// - Step codes 01, 10, 11 give 64 us, 4.1 ms, 262 ms.
// - Receive window counts from receiver wake-up, start-up included.
// - Sniffing starts only when enable is set in standby; Idle keeps RC only.
// - No signal by window end: receiver off, back to Idle.
// - Rule 0 accepts on power; rule 1 also needs a sync hit.
// - Exit 00: stay in receive, sniffing stops, host clears enable.
// - Exit 01: receive until payload or timeout, then go to mode, stop.
// - Exit 10: receive until payload or timeout, resume Idle; flush next wake.
// - Abort: write with abort set, then write with abort clear.
// - RC oscillator trims itself after power-up.
// - Host trim request; done flag sets when trim ends.
// - Auto mode: entry event goes to transit state; leave event returns.
// - Auto mode starts and ends in programmed mode; live mode write obeyed.
// - Events: queue threshold, frame sent, checksum pass, queue drain edge.
`timescale 1ns/1ps
module dcrs_sequencer
  import dcrs_pkg::*;
#(
  parameter int unsigned TRIM_CYCLES = 64
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic rc_tick,
  input wire logic [2:0] op_mode,
  input wire logic sniff_enable,
  input wire logic sniff_abort,
  input wire logic mode_write,
  input wire dcrs_phase_t idle_cfg,
  input wire dcrs_phase_t rx_cfg,
  input wire logic wake_accept_rule,
  input wire logic [1:0] sniff_exit_action,
  input wire dcrs_rxstat_t rx_stat,
  input wire logic rc_trim_begin,
  input wire dcrs_auto_t auto_cfg,
  input wire dcrs_pktev_t pkt_ev,
  output logic [2:0] active_mode,
  output logic sniff_idle,
  output logic sniff_rx,
  output logic fifo_flush,
  output logic rc_trim_busy,
  output logic rc_trim_finished,
  output logic in_transit
);
  if (TRIM_CYCLES < 1 || TRIM_CYCLES > 65535)
  begin : g_chk
    $error("TRIM_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sniff state machine
  typedef enum logic [5:0] {
    S_OFF = 6'h01,
    S_IDLE = 6'h02,
    S_WINDOW = 6'h04,
    S_HOLD = 6'h08,
    S_STOPPED = 6'h10,
    S_ABORT = 6'h20
  } dcrs_state_t;

  dcrs_state_t state_ff;
  dcrs_state_t nxt_state;
  logic [2:0] mode_ff;
  logic [2:0] nxt_mode;
  logic flush_pend_ff;
  logic flush_ff;
  logic trim_busy_ff;
  logic trim_done_ff;
  logic [15:0] trim_cnt_ff;
  logic transit_ff;
  logic drain_prev_ff;
  logic idle_start;
  logic rx_start;
  logic idle_done;
  logic rx_done;
  logic accepted;
  logic rx_end;
  logic sniff_go;
  logic entry_hit;
  logic leave_hit;
  logic [3:0] ev_vec;
  logic mode_load;
  logic nxt_transit;
  logic trim_req;
  logic trim_last;

  // Decisions on the receive path
  assign accepted = rx_stat.signal_power_threshold &&
                    (wake_accept_rule == ACCEPT_POWER || rx_stat.sync_pattern_hit);
  assign rx_end = rx_stat.payload_complete_flag || rx_stat.rx_timeout;
  // Enable counts only when raised from standby, never from other modes
  assign sniff_go = sniff_enable && !sniff_abort && (mode_ff == MODE_STDBY);
  assign idle_start = (state_ff == S_OFF && sniff_go) || nxt_state == S_IDLE && state_ff != S_IDLE;
  // Window starts at receiver wake-up, so start-up time is inside it
  assign rx_start = (state_ff == S_IDLE) && idle_done;

  dcrs_phase_timer #(
    .COEF_W(8)
  ) u_idle_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .rc_tick(rc_tick),
    .start(idle_start),
    .cfg(idle_cfg),
    .busy(),
    .done(idle_done)
  );

  dcrs_phase_timer #(
    .COEF_W(8)
  ) u_rx_tmr (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .rc_tick(rc_tick),
    .start(rx_start),
    .cfg(rx_cfg),
    .busy(),
    .done(rx_done)
  );

  // Next sniff state; abort has priority over every sniff state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_OFF:
      begin
        if (sniff_go)
        begin
          nxt_state = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (sniff_abort)
        begin
          nxt_state = S_ABORT;
        end
        else if (idle_done)
        begin
          nxt_state = S_WINDOW;
        end
      end
      S_WINDOW:
      begin
        if (sniff_abort)
        begin
          nxt_state = S_ABORT;
        end
        else if (accepted)
        begin
          nxt_state = (sniff_exit_action == EXIT_STAY) ? S_STOPPED : S_HOLD;
        end
        else if (rx_done)
        begin
          nxt_state = S_IDLE;
        end
      end
      S_HOLD:
      begin
        if (sniff_abort)
        begin
          nxt_state = S_ABORT;
        end
        else if (rx_end)
        begin
          nxt_state = (sniff_exit_action == EXIT_RESUME) ? S_IDLE : S_STOPPED;
        end
      end
      S_STOPPED:
      begin
        // Host must clear enable before a new sniff run
        if (!sniff_enable || sniff_abort)
        begin
          nxt_state = sniff_abort ? S_ABORT : S_OFF;
        end
      end
      S_ABORT:
      begin
        // Second write with abort clear releases the sequencer
        if (mode_write && !sniff_abort && !sniff_enable)
        begin
          nxt_state = S_OFF;
        end
      end
      default:
      begin
        nxt_state = S_OFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-transition events
  assign ev_vec = {drain_prev_ff && !pkt_ev.queue_has_data, pkt_ev.checksum_pass,
                   pkt_ev.frame_sent_flag, pkt_ev.queue_threshold_hit};
  assign entry_hit = ev_vec[auto_cfg.transit_entry_event];
  assign leave_hit = ev_vec[auto_cfg.transit_leave_event];

  // Mode bookkeeping: host writes land when sniffing is off; exit 01 picks op_mode
  assign mode_load = mode_write &&
                     (state_ff == S_OFF || state_ff == S_ABORT || state_ff == S_STOPPED);
  assign nxt_mode = (mode_load || (state_ff == S_HOLD && nxt_state == S_STOPPED)) ?
                    op_mode : mode_ff;

  // Sniff and mode registers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= S_OFF;
      mode_ff <= MODE_STDBY;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
    end
  end

  // Exit 10 loses queue content at the next receive wake-up
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flush_pend_ff <= 1'b0;
      flush_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      flush_ff <= rx_start && flush_pend_ff;
      if (state_ff == S_HOLD && nxt_state == S_IDLE)
      begin
        flush_pend_ff <= 1'b1;
      end
      else if (rx_start || state_ff == S_OFF)
      begin
        flush_pend_ff <= 1'b0;
      end
    end
  end

  // Transit engine; dropped in the very cycle sniffing starts, so the transit
  // mode never overlaps an Idle or receive phase
  assign nxt_transit = auto_cfg.enable && (nxt_state == S_OFF) &&
                       (transit_ff ? !leave_hit : entry_hit);
  // Drain edge history and transit flag
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      transit_ff <= 1'b0;
      drain_prev_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      drain_prev_ff <= pkt_ev.queue_has_data;
      transit_ff <= nxt_transit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RC trim: runs after reset release and on host request; a request while busy is dropped
  assign trim_req = rc_trim_begin && !trim_busy_ff;
  assign trim_last = trim_busy_ff && (trim_cnt_ff == 16'(TRIM_CYCLES - 1));
  // Counter rests at zero while idle, so a new request starts from a clean count
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trim_busy_ff <= 1'b1;
      trim_done_ff <= 1'b0;
      trim_cnt_ff <= 16'h0000;
    end
    else if (clk_en)
    begin
      trim_cnt_ff <= trim_busy_ff ? trim_cnt_ff + 16'h0001 : 16'h0000;
      if (trim_req || trim_last)
      begin
        trim_busy_ff <= trim_req;
        trim_done_ff <= trim_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic [2:0] mode_out_ff;
  logic idle_out_ff;
  logic rx_out_ff;
  logic [2:0] nxt_mode_out;
  logic nxt_rx_out;

  // Receiver stays on in the window, in hold, and after an exit 00 acceptance
  assign nxt_rx_out = (nxt_state == S_WINDOW) || (nxt_state == S_HOLD) ||
                      (nxt_state == S_STOPPED && state_ff != S_HOLD &&
                       sniff_exit_action == EXIT_STAY);
  // A stopped run keeps its mode, unless it has just left hold with exit 01
  assign nxt_mode_out = (nxt_state == S_IDLE) ? MODE_SLEEP :
                        (nxt_state == S_WINDOW || nxt_state == S_HOLD) ? MODE_RX :
                        (nxt_state == S_STOPPED && state_ff == S_WINDOW) ? MODE_RX :
                        (nxt_state == S_OFF && transit_ff) ? auto_cfg.transit_state :
                        (nxt_state != S_STOPPED || state_ff == S_HOLD) ? nxt_mode :
                        mode_out_ff;

  // Registered mode seen by the radio; Idle keeps only the RC alive
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_out_ff <= MODE_STDBY;
      idle_out_ff <= 1'b0;
      rx_out_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      idle_out_ff <= (nxt_state == S_IDLE);
      rx_out_ff <= nxt_rx_out;
      mode_out_ff <= nxt_mode_out;
    end
  end

  assign active_mode = mode_out_ff;
  assign sniff_idle = idle_out_ff;
  assign sniff_rx = rx_out_ff;
  assign fifo_flush = flush_ff;
  assign rc_trim_busy = trim_busy_ff;
  assign rc_trim_finished = trim_done_ff;
  assign in_transit = transit_ff;
endmodule

// ---- verilog/dcrs_pkg.sv ----
// Package of constants and carrier types for the duty-cycled receive sequencer
package dcrs_pkg;
  // Mode codes of the operating mode field
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STDBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  // Resolution selector codes
  localparam logic [1:0] STEP_OFF = 2'h0;
  localparam logic [1:0] STEP_FINE = 2'h1;
  localparam logic [1:0] STEP_MID = 2'h2;
  localparam logic [1:0] STEP_COARSE = 2'h3;
  // Step sizes in microseconds, turned into RC ticks of 64 us each
  localparam int unsigned STEP_FINE_US = 64;
  localparam int unsigned STEP_MID_US = 4096;
  localparam int unsigned STEP_COARSE_US = 262144;
  localparam int unsigned RC_TICK_US = 64;
  localparam logic [12:0] TICKS_FINE = 13'(STEP_FINE_US / RC_TICK_US);
  localparam logic [12:0] TICKS_MID = 13'(STEP_MID_US / RC_TICK_US);
  localparam logic [12:0] TICKS_COARSE = 13'(STEP_COARSE_US / RC_TICK_US);
  // Exit action codes
  localparam logic [1:0] EXIT_STAY = 2'h0;
  localparam logic [1:0] EXIT_TO_MODE = 2'h1;
  localparam logic [1:0] EXIT_RESUME = 2'h2;
  // Acceptance rule codes
  localparam logic ACCEPT_POWER = 1'b0;
  // Transit event selector codes
  localparam logic [1:0] EV_QUEUE_LEVEL = 2'h0;
  localparam logic [1:0] EV_FRAME_SENT = 2'h1;
  localparam logic [1:0] EV_CHECKSUM = 2'h2;
  localparam logic [1:0] EV_QUEUE_DRAIN = 2'h3;
  localparam logic [7:0] COEF_ZERO = 8'h00;

  // Sniff phase configuration
  typedef struct packed {
    logic [1:0] step_select;
    logic [7:0] step_multiplier;
  } dcrs_phase_t;

  // Auto-transition configuration
  typedef struct packed {
    logic enable;
    logic [2:0] transit_state;
    logic [1:0] transit_entry_event;
    logic [1:0] transit_leave_event;
  } dcrs_auto_t;

  // Receive-path status inputs
  typedef struct packed {
    logic signal_power_threshold;
    logic sync_pattern_hit;
    logic payload_complete_flag;
    logic rx_timeout;
  } dcrs_rxstat_t;

  // Packet-engine events for auto transitions
  typedef struct packed {
    logic queue_threshold_hit;
    logic frame_sent_flag;
    logic checksum_pass;
    logic queue_has_data;
  } dcrs_pktev_t;
endpackage

// ---- verilog/dcrs_phase_timer.sv ----
// Phase timer: multiplier times resolution step, counted in RC ticks
`timescale 1ns/1ps
module dcrs_phase_timer
  import dcrs_pkg::*;
#(
  parameter int unsigned COEF_W = 8
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic rc_tick,
  input wire logic start,
  input wire dcrs_phase_t cfg,
  output logic busy,
  output logic done
);
  if (COEF_W != 8)
  begin : g_chk
    $error("dcrs_phase_timer supports an 8-bit multiplier only");
  end

  logic [12:0] step_ff;
  logic [7:0] coef_ff;
  logic busy_ff;
  logic [12:0] step_len;
  logic step_end;

  // Reserved code 00 gives no length, so the timer never starts
  assign step_len = (cfg.step_select == STEP_FINE) ? TICKS_FINE :
                    (cfg.step_select == STEP_MID) ? TICKS_MID :
                    (cfg.step_select == STEP_COARSE) ? TICKS_COARSE : 13'h0000;
  assign step_end = rc_tick && (step_ff == 13'h0001);
  assign busy = busy_ff;
  assign done = busy_ff && step_end && (coef_ff == 8'h01);

  // Count steps down, then count multiplier down; duration = coef x step
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      step_ff <= 13'h0000;
      coef_ff <= 8'h00;
      busy_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (start && cfg.step_select != STEP_OFF && cfg.step_multiplier != COEF_ZERO)
      begin
        busy_ff <= 1'b1;
        step_ff <= step_len;
        coef_ff <= cfg.step_multiplier;
      end
      else if (busy_ff && step_end)
      begin
        step_ff <= step_len;
        coef_ff <= coef_ff - 8'h01;
        if (coef_ff == 8'h01)
        begin
          busy_ff <= 1'b0;
        end
      end
      else if (busy_ff && rc_tick)
      begin
        step_ff <= step_ff - 13'h0001;
      end
    end
  end
endmodule

// ---- dv/dcrs_checker.sv ----
// Port checks for the duty-cycled receive sequencer
`timescale 1ns/1ps
module dcrs_checker
  import dcrs_pkg::*;
#(
  parameter int unsigned TRIM_CYCLES = 64
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sniff_enable,
  input wire logic sniff_abort,
  input wire logic [2:0] active_mode,
  input wire logic sniff_idle,
  input wire logic sniff_rx,
  input wire logic fifo_flush,
  input wire logic rc_trim_busy,
  input wire logic rc_trim_finished,
  input wire logic in_transit
);
  // Slack covers the registered hand-off of the trim flags
  localparam int TRIM_LIM = TRIM_CYCLES + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////
  // Phase outputs and the modes they imply
  AST_PHASE_EXCL: assert property (!(sniff_idle && sniff_rx))
    else $error("idle and window overlap");
  AST_IDLE_SLEEP: assert property (sniff_idle |-> active_mode == MODE_SLEEP)
    else $error("idle not asleep");
  AST_RX_MODE: assert property (sniff_rx |-> active_mode == MODE_RX)
    else $error("window not in receive");
  AST_START_EN: assert property ($rose(sniff_idle) |-> $past(sniff_enable))
    else $error("idle without enable");
  AST_ABORT: assert property (sniff_abort |=> !sniff_idle && !sniff_rx)
    else $error("abort ignored");
  AST_FLUSH: assert property (fifo_flush |-> sniff_rx ##1 !fifo_flush)
    else $error("flush misplaced");
  AST_TRIM_END: assert property ($fell(rc_trim_busy) |-> ##[0:1] rc_trim_finished)
    else $error("trim done missing");
  AST_TRIM_BOUND: assert property (rc_trim_busy |-> ##[0:TRIM_LIM] !rc_trim_busy)
    else $error("trim too long");
  AST_TRANSIT_OFF: assert property (in_transit |-> !sniff_idle && !sniff_rx)
    else $error("transit while sniffing");
  // Main scenarios reached
  cover property ($rose(sniff_rx));
  cover property (fifo_flush);
  cover property ($rose(in_transit));
endmodule

bind dcrs_sequencer dcrs_checker #(.TRIM_CYCLES(TRIM_CYCLES)) i_chk (
  .ref_clk(ref_clk), .nrst(nrst), .sniff_enable(sniff_enable), .sniff_abort(sniff_abort),
  .active_mode(active_mode), .sniff_idle(sniff_idle), .sniff_rx(sniff_rx),
  .fifo_flush(fifo_flush), .rc_trim_busy(rc_trim_busy),
  .rc_trim_finished(rc_trim_finished), .in_transit(in_transit));

// ---- dv/dcrs_rc_model.sv ----
// Low-power RC oscillator model giving the sequencer its tick
`timescale 1ns/1ps
module dcrs_rc_model
#(
  parameter int unsigned TICK_DIV = 8
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  output logic rc_tick
);
  logic [7:0] div_ff;
  // Runs free: idle timing must advance while all else is off
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      {div_ff, rc_tick} <= '0;
    else
    begin
      div_ff <= (div_ff == 8'(TICK_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
      rc_tick <= (div_ff == 8'(TICK_DIV - 1));
    end
  end
endmodule

// ---- dv/duty_cycled_rx_sequencer_tb.sv ----
// Self-checking bench for the duty-cycled receive sequencer
`timescale 1ns/1ps
module duty_cycled_rx_sequencer_tb;
  import dcrs_pkg::*;
  localparam int TRIM = 4;
  localparam int DIV = 8;
  logic ref_clk, nrst, sniff_enable, sniff_abort, mode_write, wake_accept_rule;
  logic rc_trim_begin, rc_tick, look, sniff_idle, sniff_rx, fifo_flush, clk_en;
  logic rc_trim_busy, rc_trim_finished, in_transit;
  logic [2:0] op_mode, active_mode, nm;
  logic [1:0] sniff_exit_action;
  logic [31:0] cur;
  logic [31:0] q[$];
  dcrs_phase_t idle_cfg, rx_cfg, ph;
  dcrs_rxstat_t rx_stat;
  dcrs_auto_t auto_cfg;
  dcrs_pktev_t pkt_ev;
  integer seed = 32'h71d3;
  int err_count, n_checks, idle_ticks, rx_ticks, span;
  wire logic [15:0] obs = {7'h00, rc_trim_busy, in_transit, fifo_flush, rc_trim_finished,
    sniff_rx, sniff_idle, active_mode};
  //////////////////////////////////////////
  dcrs_rc_model #(.TICK_DIV(DIV)) i_rc (.ref_clk(ref_clk), .nrst(nrst), .rc_tick(rc_tick));
  dcrs_sequencer #(.TRIM_CYCLES(TRIM)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .rc_tick(rc_tick), .op_mode(op_mode), .sniff_enable(sniff_enable),
    .sniff_abort(sniff_abort), .mode_write(mode_write), .idle_cfg(idle_cfg), .rx_cfg(rx_cfg),
    .wake_accept_rule(wake_accept_rule), .sniff_exit_action(sniff_exit_action),
    .rx_stat(rx_stat), .rc_trim_begin(rc_trim_begin), .auto_cfg(auto_cfg), .pkt_ev(pkt_ev),
    .active_mode(active_mode), .sniff_idle(sniff_idle), .sniff_rx(sniff_rx),
    .fifo_flush(fifo_flush), .rc_trim_busy(rc_trim_busy),
    .rc_trim_finished(rc_trim_finished), .in_transit(in_transit));
  // Clock and RC tick tally per phase
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    idle_ticks += int'(sniff_idle && rc_tick);
    rx_ticks += int'(sniff_rx && rc_tick);
  end
  // Watcher: oldest note against settled outputs
  always @(negedge ref_clk)
  begin
    if (look)
    begin
      cur = q.pop_front();
      n_checks++;
      if ((obs & cur[31:16]) !== cur[15:0])
      begin
        err_count++;
        $display("unexpected at %0t: got %h want %h", $time, obs & cur[31:16], cur[15:0]);
      end
    end
  end
  //////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic nt(input logic [15:0] m, input logic [15:0] e);
    q.push_back({m, e});
    look = 1'b1;
    tk(1);
    look = 1'b0;
  endtask
  // Bounded wait, then the note lands in the cycle the result shows
  task automatic wt(input logic [15:0] m, input logic [15:0] e, input int lim);
    for (int i = 0; i < lim && (obs & m) !== e; i++)
      tk(1);
    nt(m, e);
  endtask
  // RC phases start on random tick phase, so one tick of slack is allowed
  task automatic span_chk(input int got, input int want);
    n_checks++;
    if (got < want - 1 || got > want + 1)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [2:0] m, input logic en, input logic ab);
    {op_mode, sniff_enable, sniff_abort, mode_write} = {m, en, ab, 1'b1};
    tk(1);
    mode_write = 1'b0;
  endtask
  task automatic abort_to(input logic [2:0] m);
    wr(m, 1'b0, 1'b1);
    tk(1);
    wr(m, 1'b0, 1'b0);
    wt(16'h009f, {13'h0, m}, 6);
  endtask
  task automatic go(input dcrs_phase_t ic, input dcrs_phase_t rc, input logic [1:0] ex);
    {idle_cfg, rx_cfg, sniff_exit_action} = {ic, rc, ex};
    wr(MODE_STDBY, 1'b0, 1'b0);
    sniff_enable = 1'b1;
    {idle_ticks, rx_ticks} = '0;
    wt(16'h001f, 16'h0008, 6);
  endtask
  task automatic fire(input int c);
    if (c % 4 == 3)
      pkt_ev.queue_has_data = 1'b0;
    else
      pkt_ev[3 - c % 4] = 1'b1;
    tk(1);
    pkt_ev = 4'h1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////
  initial
  begin
    #(40000 * 25);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial
  begin
    {nrst, sniff_enable, sniff_abort, mode_write, wake_accept_rule, rc_trim_begin, look} = '0;
    {op_mode, sniff_exit_action, idle_cfg, rx_cfg, rx_stat, auto_cfg} = {MODE_STDBY, 34'h0};
    clk_en = 1'b1;
    pkt_ev = 4'h1;
    repeat (15) @(posedge ref_clk);
    nt(16'h0127, 16'h0101);
    nrst = 1'b1;
    wt(16'h0120, 16'h0020, TRIM + 8);
    rc_trim_begin = 1'b1;
    tk(1);
    rc_trim_begin = 1'b0;
    wt(16'h0100, 16'h0100, 4);
    // Three frozen cycles: trim must still be busy when it would otherwise have ended
    clk_en = 1'b0;
    tk(3);
    clk_en = 1'b1;
    nt(16'h0120, 16'h0100);
    wt(16'h0120, 16'h0020, TRIM + 8);
    $display("test trim done");
    for (int i = 0; i < 3; i++)
    begin
      ph = '{i == 1 ? STEP_MID : STEP_FINE, i == 2 ? 8'hff : 8'(1 + ($random(seed) & 3))};
      span = ph.step_multiplier * (ph.step_select == STEP_MID ? int'(TICKS_MID) : 1);
      go(ph, '{STEP_FINE, 8'h03}, EXIT_RESUME);
      wt(16'h001f, 16'h0014, span * DIV + 40);
      span_chk(idle_ticks, span);
      wt(16'h001f, 16'h0008, 3 * DIV + 40);
      span_chk(rx_ticks, 3);
      abort_to(MODE_STDBY);
    end
    $display("test timing done");
    for (int i = 0; i < 6; i++)
    begin
      wake_accept_rule = i[0];
      rx_stat = 4'h8;
      go('{STEP_FINE, 8'h02}, '{STEP_FINE, 8'h04}, 2'(i / 2));
      wt(16'h001f, 16'h0014, 80);
      if (i[0])
      begin
        wt(16'h001f, 16'h0008, 80);
        rx_stat.sync_pattern_hit = 1'b1;
        wt(16'h001f, 16'h0014, 80);
      end
      tk(6 * DIV);
      nt(16'h001f, 16'h0014);
      if (i / 2 != 0)
      begin
        rx_stat.payload_complete_flag = 1'b1;
        tk(1);
        rx_stat = 4'h0;
        wt(16'h001f, i / 2 == 1 ? 16'h0001 : 16'h0008, 6);
        if (i / 2 == 2)
          wt(16'h0050, 16'h0050, 80);
      end
      abort_to(3'(i % 5));
    end
    $display("test accept done");
    go('{STEP_OFF, 8'h03}, '{STEP_FINE, 8'h01}, EXIT_RESUME);
    tk(40 * DIV);
    nt(16'h001f, 16'h0008);
    abort_to(MODE_STDBY);
    $display("test reserved done");
    for (int e = 0; e < 4; e++)
    begin
      nm = 3'($unsigned($random(seed)) % 5);
      auto_cfg = '{1'b1, 3'($unsigned($random(seed)) % 5), 2'(e), 2'(e + 1)};
      fire(e);
      wt(16'h0087, {8'h0, 1'b1, 4'h0, auto_cfg.transit_state}, 8);
      wr(nm, 1'b0, 1'b0);
      fire(e + 1);
      wt(16'h0087, {13'h0, nm}, 8);
    end
    auto_cfg.enable = 1'b0;
    $display("test auto done");
    tally_and_finish();
  end
endmodule
